/* File: rtl/cpu_irq_regs.svh */
/*
 * Register offsets, field positions, reset values and pin indices
 * for the clock and power unit interrupt block.
 * Assumes a Wishbone slave with byte addresses on a 32-bit data bus.
 */
`ifndef CPU_IRQ_REGS_SVH
`define CPU_IRQ_REGS_SVH

`define CPI_CTRL_OFF 8'h00
`define CPI_TICK_RATE_OFF 8'h04
`define CPI_WAKE_PERIOD_OFF 8'h08
`define CPI_IRQ_ENABLE_OFF 8'h0C
`define CPI_FLAGS_OFF 8'h10
`define CPI_STATUS_OFF 8'h14

`define CPI_CTRL_TICK_SEL 0
`define CPI_CTRL_PSTOP_SEL 1
`define CPI_CTRL_OSC_PSTOP 2
`define CPI_CTRL_OSC_EN 3
`define CPI_CTRL_WAKE_EN 4
`define CPI_CTRL_WAKE_CLK 5
`define CPI_CTRL_WAKE_PIN 6
`define CPI_CTRL_TRIM_LSB 8
`define CPI_CTRL_TRIM_MSB 13

`define CPI_SRC_TICK 0
`define CPI_SRC_LOCK 1
`define CPI_SRC_OSC 2
`define CPI_SRC_LV 3
`define CPI_SRC_HT 4
`define CPI_SRC_WAKE 5

`define CPI_ST_LOCK 0
`define CPI_ST_QUAL 1
`define CPI_ST_LV 2
`define CPI_ST_HT 3

`define CPI_PIN_IRC 0
`define CPI_PIN_OSC 1
`define CPI_PIN_ACLK 2
`define CPI_PIN_LOCK 3
`define CPI_PIN_STOP 4
`define CPI_PIN_FULL_PERF 5
`define CPI_PIN_BUSOFF 6
`define CPI_PIN_LV_BELOW 7
`define CPI_PIN_LV_ABOVE 8
`define CPI_PIN_HT_ABOVE 9
`define CPI_PIN_HT_BELOW 10
`define CPI_PIN_COUNT 11

`define CPI_CTRL_RESET 14'h0000
`define CPI_TICK_RATE_RESET 8'h00
`define CPI_WAKE_PERIOD_RESET 16'h0000

`endif

/* File: rtl/cpu_irq_pkg.sv */
/*
 * Types shared by the clock and power unit interrupt block.
 * Assumes the constants header is compiled alongside.
 */
package cpu_irq_pkg;
    typedef logic [5:0] irq_vec_t;
    typedef logic [7:0] tick_count_t;
    typedef logic [15:0] wake_count_t;
    typedef logic [13:0] ctrl_t;
    typedef logic [10:0] pin_vec_t;
endpackage

/* File: rtl/clock_power_irq.sv */
/*
 * Interrupt sources of a clock, reset and power unit: tick timer,
 * lock change, oscillator status, low voltage, high temperature and
 * autonomous wakeup timer, behind a classic Wishbone slave.
 * Assumes all pin inputs except pll_config_change_i are asynchronous; the RC, crystal and
 * autonomous clocks are far slower than clk_i and are sampled.
 */
// Our own choices: register access over Wishbone and the register addresses.
// Contract
// - Tick timer counts internal RC or crystal clock per tick select bit.
// - In stop, tick runs only with pseudo stop, crystal, osc-in-stop set.
// - Tick timeout sets tick flag and restarts next period at once.
// - Tick interrupt at programmed rate only while its enable is set.
// - Any write to tick rate register restarts current tick period.
// - Lock change flag sets on each lock toggle, either direction.
// - Lock change flag clears only by writing one; zero leaves it.
// - Lock change interrupt suppressed while its enable is zero.
// - Oscillator qualified stays zero when disabled; sets after lock.
// - Any change of oscillator qualified sets oscillator status flag.
// - PLL configuration change or lock loss clears oscillator qualified.
// - Oscillator status interrupt only while its enable is set.
// - In full performance, low voltage bit sets below, clears above.
// - Each low voltage status change sets flag; enable gates interrupt.
// - High temp status follows comparator in full performance; changes set flag, enable gates irq.
// - Wakeup timer runs only while enabled, starting the period at once.
// - Wakeup clock is autonomous RC or bus; select writable when off.
// - 16-bit wakeup period writable only while the timer is disabled.
// - Wakeup interval expiry sets flag and restarts; enable gates irq.
// - Wakeup count freezes when bus clock selected and turned off.
// - Enable plus pin output enable drive a waveform on wakeup pin.
`timescale 1ns/1ns
`include "cpu_irq_regs.svh"

module clock_power_irq (
    // Clock and reset
    input wire logic clk_i,
    input wire logic rst_i,
    // Wishbone slave
    input wire logic cyc_i,
    input wire logic stb_i,
    input wire logic we_i,
    input wire logic [7:0] adr_i,
    input wire logic [3:0] sel_i,
    input wire logic [31:0] dat_i,
    output logic [31:0] dat_o,
    output logic ack_o,
    // Clock and power pins
    input wire logic internal_rc_clock_i,
    input wire logic crystal_clock_i,
    input wire logic autonomous_rc_clock_i,
    input wire logic pll_lock_i,
    input wire logic stop_mode_i,
    input wire logic full_performance_mode_i,
    input wire logic bus_clock_off_i,
    input wire logic supply_below_assert_i,
    input wire logic supply_above_deassert_i,
    input wire logic temp_above_assert_i,
    input wire logic temp_below_deassert_i,
    // Same-clock pulse from PLL configuration logic
    input wire logic pll_config_change_i,
    // Requests and waveform
    output cpu_irq_pkg::irq_vec_t irq_o,
    output logic wakeup_waveform_pin_o
);

    cpu_irq_pkg::pin_vec_t pins;
    cpu_irq_pkg::pin_vec_t sync1_q;
    cpu_irq_pkg::pin_vec_t sync2_q;
    cpu_irq_pkg::pin_vec_t prev_q;
    cpu_irq_pkg::ctrl_t ctrl_q;
    cpu_irq_pkg::tick_count_t tick_rate_q;
    cpu_irq_pkg::tick_count_t tick_cnt_q;
    cpu_irq_pkg::wake_count_t wake_period_q;
    cpu_irq_pkg::wake_count_t wake_cnt_q;
    cpu_irq_pkg::irq_vec_t enable_q;
    cpu_irq_pkg::irq_vec_t flags_q;
    cpu_irq_pkg::irq_vec_t flag_set;
    cpu_irq_pkg::irq_vec_t flag_clr;
    logic [31:0] wmask;
    logic [31:0] rdata;
    logic req;
    logic wr;
    logic wr_ctrl;
    logic wr_rate;
    logic wr_period;
    logic lock_s;
    logic full_stop;
    logic qual_q;
    logic lv_q;
    logic ht_q;
    logic tick_src;
    logic tick_run;
    logic tick_expire;
    logic wake_en;
    logic wake_src;
    logic wake_expire;
    logic wave_q;

    assign pins = {temp_below_deassert_i, temp_above_assert_i,
                   supply_above_deassert_i, supply_below_assert_i,
                   bus_clock_off_i, full_performance_mode_i, stop_mode_i,
                   pll_lock_i, autonomous_rc_clock_i, crystal_clock_i,
                   internal_rc_clock_i};

    // Two-stage synchronisers; prev_q only feeds edge detection
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            sync1_q <= '0;
            sync2_q <= '0;
            prev_q <= '0;
        end else begin
            sync1_q <= pins;
            sync2_q <= sync1_q;
            prev_q <= sync2_q;
        end
    end

    assign lock_s = sync2_q[`CPI_PIN_LOCK];
    assign full_stop = sync2_q[`CPI_PIN_STOP] & ~ctrl_q[`CPI_CTRL_PSTOP_SEL];

    // Bus decode; writes land on the edge that raises ack
    assign req = cyc_i & stb_i & ~ack_o;
    assign wr = req & we_i;
    assign wr_ctrl = wr && adr_i == `CPI_CTRL_OFF;
    assign wr_rate = wr && adr_i == `CPI_TICK_RATE_OFF;
    assign wr_period = wr && adr_i == `CPI_WAKE_PERIOD_OFF;
    assign wmask = {{8{sel_i[3]}}, {8{sel_i[2]}}, {8{sel_i[1]}},
                    {8{sel_i[0]}}};
    assign wake_en = ctrl_q[`CPI_CTRL_WAKE_EN];

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            ack_o <= 1'b0;
            dat_o <= '0;
        end else begin
            ack_o <= req;
            if (req) begin
                dat_o <= we_i ? 32'h0000_0000 : rdata;
            end
        end
    end

    always_comb begin
        rdata = 32'h0000_0000;
        case (adr_i)
            `CPI_CTRL_OFF: rdata[13:0] = ctrl_q;
            `CPI_TICK_RATE_OFF: rdata[7:0] = tick_rate_q;
            `CPI_WAKE_PERIOD_OFF: rdata[15:0] = wake_period_q;
            `CPI_IRQ_ENABLE_OFF: rdata[5:0] = enable_q;
            `CPI_FLAGS_OFF: rdata[5:0] = flags_q;
            `CPI_STATUS_OFF: rdata[3:0] = {ht_q, lv_q, qual_q, lock_s};
            default: rdata = 32'h0000_0000;
        endcase
    end

    // Control register; wakeup clock select frozen while timer runs
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            ctrl_q <= `CPI_CTRL_RESET;
        end else if (wr_ctrl) begin
            ctrl_q <= (ctrl_q & ~wmask[13:0]) | (dat_i[13:0] & wmask[13:0]);
            if (wake_en) begin
                ctrl_q[`CPI_CTRL_WAKE_CLK]
                    <= ctrl_q[`CPI_CTRL_WAKE_CLK];
            end
        end
    end

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            tick_rate_q <= `CPI_TICK_RATE_RESET;
            wake_period_q <= `CPI_WAKE_PERIOD_RESET;
            enable_q <= '0;
        end else begin
            if (wr_rate) begin
                tick_rate_q <= (tick_rate_q & ~wmask[7:0])
                               | (dat_i[7:0] & wmask[7:0]);
            end
            if (wr_period && !wake_en) begin
                wake_period_q <= (wake_period_q & ~wmask[15:0])
                                 | (dat_i[15:0] & wmask[15:0]);
            end
            if (wr && adr_i == `CPI_IRQ_ENABLE_OFF) begin
                enable_q <= (enable_q & ~wmask[5:0])
                            | (dat_i[5:0] & wmask[5:0]);
            end
        end
    end

    // Tick timer; period is rate + 1 source edges
    assign tick_src = ctrl_q[`CPI_CTRL_TICK_SEL]
        ? sync2_q[`CPI_PIN_OSC] & ~prev_q[`CPI_PIN_OSC]
        : sync2_q[`CPI_PIN_IRC] & ~prev_q[`CPI_PIN_IRC];
    assign tick_run = ~sync2_q[`CPI_PIN_STOP]
        | (ctrl_q[`CPI_CTRL_PSTOP_SEL] & ctrl_q[`CPI_CTRL_TICK_SEL]
           & ctrl_q[`CPI_CTRL_OSC_PSTOP]);
    assign tick_expire = tick_src & tick_run & ~wr_rate
                         & (tick_cnt_q == tick_rate_q);

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            tick_cnt_q <= '0;
        end else if (wr_rate) begin
            tick_cnt_q <= '0;
        end else if (tick_expire) begin
            tick_cnt_q <= '0;
        end else if (tick_src && tick_run) begin
            tick_cnt_q <= tick_cnt_q + 8'h01;
        end
    end

    // Oscillator qualified and supply and temperature status
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            qual_q <= 1'b0;
            lv_q <= 1'b0;
            ht_q <= 1'b0;
        end else begin
            if (!ctrl_q[`CPI_CTRL_OSC_EN] || full_stop) begin
                qual_q <= 1'b0;
            end else if (!lock_s || pll_config_change_i) begin
                qual_q <= 1'b0;
            end else begin
                qual_q <= 1'b1;
            end
            if (sync2_q[`CPI_PIN_FULL_PERF]) begin
                if (sync2_q[`CPI_PIN_LV_BELOW]) begin
                    lv_q <= 1'b1;
                end else if (sync2_q[`CPI_PIN_LV_ABOVE]) begin
                    lv_q <= 1'b0;
                end
                if (sync2_q[`CPI_PIN_HT_ABOVE]) begin
                    ht_q <= 1'b1;
                end else if (sync2_q[`CPI_PIN_HT_BELOW]) begin
                    ht_q <= 1'b0;
                end
            end
        end
    end

    // Wakeup timer; bus clock source counts every clk_i cycle
    assign wake_src = ctrl_q[`CPI_CTRL_WAKE_CLK]
        ? ~sync2_q[`CPI_PIN_BUSOFF]
        : sync2_q[`CPI_PIN_ACLK] & ~prev_q[`CPI_PIN_ACLK];
    assign wake_expire = wake_en & wake_src & (wake_cnt_q == wake_period_q);

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            wake_cnt_q <= '0;
            wave_q <= 1'b0;
        end else if (!wake_en) begin
            wake_cnt_q <= '0;
            wave_q <= 1'b0;
        end else if (wake_expire) begin
            wake_cnt_q <= '0;
            wave_q <= ~wave_q;
        end else if (wake_src) begin
            wake_cnt_q <= wake_cnt_q + 16'h0001;
        end
    end

    // Pin stays low unless both enables are set
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            wakeup_waveform_pin_o <= 1'b0;
        end else begin
            wakeup_waveform_pin_o <= wake_en & ctrl_q[`CPI_CTRL_WAKE_PIN]
                                     & wave_q;
        end
    end

    // Flags: hardware set beats a write-one clear in the same cycle
    always_comb begin
        flag_set = '0;
        flag_set[`CPI_SRC_TICK] = tick_expire;
        flag_set[`CPI_SRC_LOCK] = lock_s ^ prev_q[`CPI_PIN_LOCK];
        flag_set[`CPI_SRC_OSC] = 1'b0;
        flag_set[`CPI_SRC_LV] = 1'b0;
        flag_set[`CPI_SRC_HT] = 1'b0;
        flag_set[`CPI_SRC_WAKE] = wake_expire;
    end

    logic qual_prev_q;
    logic lv_prev_q;
    logic ht_prev_q;
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            qual_prev_q <= 1'b0;
            lv_prev_q <= 1'b0;
            ht_prev_q <= 1'b0;
        end else begin
            qual_prev_q <= qual_q;
            lv_prev_q <= lv_q;
            ht_prev_q <= ht_q;
        end
    end

    cpu_irq_pkg::irq_vec_t status_set;
    assign status_set = {1'b0, ht_q ^ ht_prev_q, lv_q ^ lv_prev_q,
                         qual_q ^ qual_prev_q, 2'b00};
    assign flag_clr = (wr && adr_i == `CPI_FLAGS_OFF)
                      ? dat_i[5:0] & wmask[5:0] : 6'h00;

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            flags_q <= '0;
        end else begin
            flags_q <= (flags_q & ~flag_clr) | flag_set | status_set;
        end
    end

    // Gated requests, one per source
    assign irq_o = flags_q & enable_q;

    default clocking cb @(posedge clk_i);
    endclocking
    default disable iff (rst_i);

    a_tick_restart: assert property (tick_expire |=>
        flags_q[`CPI_SRC_TICK] && tick_cnt_q == 8'h00)
        else $error("tick period did not restart with flag set");
    a_rate_write: assert property (wr_rate |=> tick_cnt_q == 8'h00)
        else $error("tick rate write did not restart period");
    a_tick_halt: assert property (!tick_run && !wr_rate |=>
        $stable(tick_cnt_q))
        else $error("tick counter moved while halted in stop");
    a_lock_edge: assert property (lock_s != prev_q[`CPI_PIN_LOCK] |=>
        flags_q[`CPI_SRC_LOCK])
        else $error("lock toggle did not set lock change flag");
    a_lock_keep: assert property (flags_q[`CPI_SRC_LOCK]
        && !flag_clr[`CPI_SRC_LOCK] |=> flags_q[`CPI_SRC_LOCK])
        else $error("lock change flag cleared without a one write");
    a_qual_off: assert property (!ctrl_q[`CPI_CTRL_OSC_EN] |=>
        !qual_q)
        else $error("oscillator qualified set while oscillator off");
    a_qual_flag: assert property ($changed(qual_q) |=>
        flags_q[`CPI_SRC_OSC])
        else $error("qualified change did not set oscillator flag");
    a_wake_expiry: assert property (wake_expire |=>
        flags_q[`CPI_SRC_WAKE] && wake_cnt_q == 16'h0000)
        else $error("wakeup expiry did not set flag and restart");
    a_period_locked: assert property (wake_en |=>
        $stable(wake_period_q))
        else $error("wakeup period changed while timer enabled");
    a_wake_freeze: assert property (wake_en
        && ctrl_q[`CPI_CTRL_WAKE_CLK] && sync2_q[`CPI_PIN_BUSOFF]
        |=> $stable(wake_cnt_q))
        else $error("wakeup count moved with bus clock off");
    a_wave_gate: assert property (!wake_en |=>
        !wakeup_waveform_pin_o)
        else $error("waveform pin driven while timer disabled");
    a_tick_bound: assert property (tick_cnt_q <= tick_rate_q)
        else $error("tick count ran past the programmed rate");
    a_wake_idle: assert property (!wake_en |=>
        wake_cnt_q == 16'h0000)
        else $error("wakeup count not held at zero while disabled");
    a_pin_gate: assert property (!ctrl_q[`CPI_CTRL_WAKE_PIN] |=>
        !wakeup_waveform_pin_o)
        else $error("waveform pin driven without pin output enable");
    a_flag_clear: assert property (flag_clr[`CPI_SRC_TICK]
        && !flag_set[`CPI_SRC_TICK] |=> !flags_q[`CPI_SRC_TICK])
        else $error("tick flag survived a one write");
    a_lv_hold: assert property (!sync2_q[`CPI_PIN_FULL_PERF] |=>
        $stable(lv_q))
        else $error("low voltage status moved outside full performance");
    a_qual_lock: assert property (!lock_s |=> !qual_q)
        else $error("oscillator qualified set without lock");
    a_lv_flag: assert property (lv_q != lv_prev_q |=>
        flags_q[`CPI_SRC_LV])
        else $error("low voltage change did not set its flag");

    c_tick_expire: cover property (tick_expire ##1 irq_o[`CPI_SRC_TICK]);
    c_lock_loss: cover property ($fell(lock_s) ##1 flags_q[`CPI_SRC_LOCK]);
    c_wake_wave: cover property ($rose(wakeup_waveform_pin_o));
    c_set_clear: cover property (|(flag_set & flag_clr));

endmodule

/* File: verif/tb_clock_power_irq.sv */
/*
 * Self-checking bench for the clock and power interrupt block.
 * Assumes a classic Wishbone master and slow clocks made here.
 */
`timescale 1ns/1ns
`include "cpu_irq_regs.svh"

module tb_clock_power_irq;
    localparam logic [7:0] A_CTL = `CPI_CTRL_OFF;
    localparam logic [7:0] A_RATE = `CPI_TICK_RATE_OFF;
    localparam logic [7:0] A_PER = `CPI_WAKE_PERIOD_OFF;
    localparam logic [7:0] A_EN = `CPI_IRQ_ENABLE_OFF;
    localparam logic [7:0] A_FLG = `CPI_FLAGS_OFF;
    localparam logic [7:0] A_ST = `CPI_STATUS_OFF;
    // Ceiling well above the roughly 900 cycles of the run
    localparam int LIMIT = 20000;
    logic clk_i = 1'b0;
    logic rst_i = 1'b1;
    logic cyc = 1'b0;
    logic stb = 1'b0;
    logic we = 1'b0;
    logic [7:0] adr = 8'h00;
    logic [3:0] sel = 4'h0;
    logic [31:0] dat_w = 32'h00000000;
    logic [31:0] dat_r;
    logic ack;
    // Slow clocks: rc, crystal, autonomous
    logic [2:0] slow = 3'h0;
    logic lock = 1'b0;
    logic stop = 1'b0;
    logic full_perf = 1'b0;
    logic boff = 1'b0;
    logic below = 1'b0;
    logic above = 1'b0;
    logic hot = 1'b0;
    logic cool = 1'b0;
    logic cfg = 1'b0;
    cpu_irq_pkg::irq_vec_t irq;
    logic wave;
    int fail_count = 0;
    int n_tests = 0;
    int cycles = 0;

    clock_power_irq i_dut (
        .clk_i(clk_i), .rst_i(rst_i), .cyc_i(cyc), .stb_i(stb), .we_i(we),
        .adr_i(adr), .sel_i(sel), .dat_i(dat_w), .dat_o(dat_r), .ack_o(ack),
        .internal_rc_clock_i(slow[0]), .crystal_clock_i(slow[1]),
        .autonomous_rc_clock_i(slow[2]), .pll_lock_i(lock),
        .stop_mode_i(stop), .full_performance_mode_i(full_perf),
        .bus_clock_off_i(boff), .supply_below_assert_i(below),
        .supply_above_deassert_i(above), .temp_above_assert_i(hot),
        .temp_below_deassert_i(cool), .pll_config_change_i(cfg),
        .irq_o(irq), .wakeup_waveform_pin_o(wave)
    );

    initial begin
        forever #50 clk_i = ~clk_i;
    end

    task automatic end_of_test;
        $display("checks %0d mismatches %0d", n_tests, fail_count);
        if (fail_count == 0 && n_tests > 0) begin
            $display("Simulation passed");
        end else begin
            $display("Simulation failed");
        end
        $finish;
    endtask

    initial begin
        while (cycles < LIMIT) begin
            @(posedge clk_i);
            cycles++;
        end
        fail_count++;
        $display("ERROR t=%0t timeout", $time);
        end_of_test;
    end

    task automatic chk(input logic [31:0] g, input logic [31:0] e);
        n_tests++;
        if (g !== e) begin
            fail_count++;
            $display("ERROR t=%0t got %h exp %h", $time, g, e);
        end
    endtask

    // Request held until ack is sampled; answer taken at that edge
    // No wait limit here: only the watchdog ends a hang
    task automatic bus(input logic w, input logic [7:0] a,
                       input logic [31:0] d, output logic [31:0] q);
        @(posedge clk_i);
        cyc <= 1'b1;
        stb <= 1'b1;
        we <= w;
        adr <= a;
        dat_w <= d;
        sel <= 4'hF;
        do begin
            @(posedge clk_i);
        end while (ack !== 1'b1);
        q = dat_r;
        cyc <= 1'b0;
        stb <= 1'b0;
        we <= 1'b0;
    endtask

    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        logic [31:0] q;
        bus(1'b1, a, d, q);
    endtask

    task automatic rd_chk(input logic [7:0] a, input logic [31:0] e);
        logic [31:0] q;
        bus(1'b0, a, 32'h00000000, q);
        chk(q, e);
    endtask

    task automatic idle(input int n);
        repeat (n) @(posedge clk_i);
    endtask

    // Each level held 3 cycles: slower than the 2-flop sampler needs
    task automatic pulse(input int i, input int n);
        repeat (n) begin
            @(posedge clk_i);
            slow[i] <= 1'b1;
            idle(3);
            slow[i] <= 1'b0;
            idle(2);
        end
    endtask

    task automatic t_reset;
        for (int a = 0; a <= 20; a += 4) begin
            rd_chk(8'(a), 32'h00000000);
        end
        chk({26'h0, irq}, 32'h00000000);
        wr(8'h40, 32'hFFFFFFFF);
        rd_chk(8'h40, 32'h00000000);
        rd_chk(A_CTL, 32'h00000000);
        wr(A_CTL, 32'h00003F40);
        rd_chk(A_CTL, 32'h00003F40);
        wr(A_CTL, 32'h00000000);
        $display("reset test done");
    endtask

    task automatic t_tick;
        wr(A_FLG, 32'h0000003F);
        wr(A_RATE, 32'h00000002);
        pulse(1, 3);
        rd_chk(A_FLG, 32'h00000000);
        pulse(0, 2);
        wr(A_RATE, 32'h00000002);
        pulse(0, 2);
        rd_chk(A_FLG, 32'h00000000);
        pulse(0, 1);
        rd_chk(A_FLG, 32'h00000001);
        chk({26'h0, irq}, 32'h00000000);
        wr(A_EN, 32'h00000001);
        chk({26'h0, irq}, 32'h00000001);
        wr(A_FLG, 32'h00000000);
        rd_chk(A_FLG, 32'h00000001);
        wr(A_FLG, 32'h00000001);
        rd_chk(A_FLG, 32'h00000000);
        chk({26'h0, irq}, 32'h00000000);
        pulse(0, 3);
        rd_chk(A_FLG, 32'h00000001);
        wr(A_FLG, 32'h00000001);
        wr(A_CTL, 32'h00000001);
        pulse(0, 3);
        rd_chk(A_FLG, 32'h00000000);
        pulse(1, 3);
        rd_chk(A_FLG, 32'h00000001);
        wr(A_FLG, 32'h00000001);
        stop <= 1'b1;
        pulse(1, 3);
        rd_chk(A_FLG, 32'h00000000);
        wr(A_CTL, 32'h00000007);
        pulse(1, 3);
        rd_chk(A_FLG, 32'h00000001);
        stop <= 1'b0;
        wr(A_CTL, 32'h00000000);
        wr(A_EN, 32'h00000000);
        $display("tick test done");
    endtask

    task automatic t_lock;
        wr(A_FLG, 32'h0000003F);
        wr(A_EN, 32'h00000002);
        lock <= 1'b1;
        idle(6);
        rd_chk(A_FLG, 32'h00000002);
        chk({26'h0, irq}, 32'h00000002);
        wr(A_FLG, 32'h00000000);
        rd_chk(A_FLG, 32'h00000002);
        wr(A_EN, 32'h00000000);
        chk({26'h0, irq}, 32'h00000000);
        wr(A_FLG, 32'h00000002);
        rd_chk(A_FLG, 32'h00000000);
        lock <= 1'b0;
        idle(6);
        rd_chk(A_FLG, 32'h00000002);
        $display("lock test done");
    endtask

    task automatic t_osc;
        lock <= 1'b1;
        idle(6);
        wr(A_FLG, 32'h0000003F);
        rd_chk(A_ST, 32'h00000001);
        wr(A_CTL, 32'h00000008);
        idle(4);
        rd_chk(A_ST, 32'h00000003);
        rd_chk(A_FLG, 32'h00000004);
        wr(A_EN, 32'h00000004);
        chk({26'h0, irq}, 32'h00000004);
        wr(A_EN, 32'h00000000);
        chk({26'h0, irq}, 32'h00000000);
        wr(A_FLG, 32'h0000003F);
        @(posedge clk_i);
        cfg <= 1'b1;
        @(posedge clk_i);
        cfg <= 1'b0;
        idle(4);
        rd_chk(A_FLG, 32'h00000004);
        wr(A_FLG, 32'h0000003F);
        lock <= 1'b0;
        idle(6);
        rd_chk(A_ST, 32'h00000000);
        rd_chk(A_FLG, 32'h00000006);
        wr(A_CTL, 32'h00000000);
        $display("oscillator test done");
    endtask

    task automatic t_lvht;
        wr(A_FLG, 32'h0000003F);
        wr(A_EN, 32'h00000018);
        below <= 1'b1;
        idle(6);
        rd_chk(A_ST, 32'h00000000);
        full_perf <= 1'b1;
        idle(6);
        rd_chk(A_ST, 32'h00000004);
        rd_chk(A_FLG, 32'h00000008);
        chk({26'h0, irq}, 32'h00000008);
        wr(A_FLG, 32'h00000008);
        below <= 1'b0;
        above <= 1'b1;
        hot <= 1'b1;
        idle(6);
        rd_chk(A_ST, 32'h00000008);
        rd_chk(A_FLG, 32'h00000018);
        chk({26'h0, irq}, 32'h00000018);
        wr(A_FLG, 32'h00000018);
        hot <= 1'b0;
        cool <= 1'b1;
        idle(6);
        rd_chk(A_ST, 32'h00000000);
        rd_chk(A_FLG, 32'h00000010);
        wr(A_EN, 32'h00000000);
        $display("voltage and temperature test done");
    endtask

    task automatic t_wake;
        logic w0;
        wr(A_FLG, 32'h0000003F);
        wr(A_EN, 32'h00000020);
        wr(A_PER, 32'h00000001);
        wr(A_CTL, 32'h00000010);
        pulse(2, 1);
        rd_chk(A_FLG, 32'h00000000);
        pulse(2, 1);
        rd_chk(A_FLG, 32'h00000020);
        chk({26'h0, irq}, 32'h00000020);
        wr(A_PER, 32'h00000005);
        wr(A_CTL, 32'h00000030);
        rd_chk(A_CTL, 32'h00000010);
        rd_chk(A_PER, 32'h00000001);
        wr(A_CTL, 32'h00000000);
        wr(A_FLG, 32'h0000003F);
        pulse(2, 4);
        rd_chk(A_FLG, 32'h00000000);
        wr(A_PER, 32'h0000003F);
        rd_chk(A_PER, 32'h0000003F);
        wr(A_CTL, 32'h00000020);
        wr(A_CTL, 32'h00000070);
        rd_chk(A_FLG, 32'h00000000);
        idle(70);
        rd_chk(A_FLG, 32'h00000020);
        // Exactly one toggle in any 64-cycle span
        w0 = wave;
        idle(64);
        chk({31'h0, wave}, {31'h0, ~w0});
        boff <= 1'b1;
        idle(4);
        wr(A_FLG, 32'h0000003F);
        idle(200);
        rd_chk(A_FLG, 32'h00000000);
        boff <= 1'b0;
        idle(80);
        rd_chk(A_FLG, 32'h00000020);
        wr(A_CTL, 32'h00000000);
        $display("wakeup test done");
    endtask

    initial begin
        repeat (3) @(posedge clk_i);
        rst_i <= 1'b0;
        t_reset;
        t_tick;
        t_lock;
        t_osc;
        t_lvht;
        t_wake;
        end_of_test;
    end
endmodule
